// *** design/cpm_ctrl.sv ***
// cpm_ctrl: clock source selection and power mode control behind APB.
// assumes an APB master, asynchronous pins for interrupts, lock and clock.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module cpm_ctrl #(
   parameter int SLEEP_RESUME_CYC = cpm_pkg::SLEEP_CYC,
   parameter int STOP_RESUME_CYC  = cpm_pkg::STOP_CYC
) (
   input  wire logic                   mclk,
   input  wire logic                   nrst,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [cpm_pkg::AW-1:0] paddr,
   input  wire logic [cpm_pkg::DW-1:0] pwdata,
   output logic      [cpm_pkg::DW-1:0] prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   extClkPin,
   input  wire logic                   pllLockIn,
   input  wire logic [3:0]             extIrqIn,
   input  wire logic                   wakeTimerIrq,
   output logic                        coreClkEn,
   output logic                        periphClkEn,
   output logic                        pllEn,
   output logic                        xtalTimerEn,
   output logic                        extClkSelect,
   output logic                        pllRefInternal,
   output logic                        coreTick,
   output logic                        pllIrq
);
   import cpm_pkg::*;

   logic [CW-1:0]         pwrCtl_q;
   logic [CW-1:0]         clkCtl_q;
   logic [CW-1:0]         stage_q;
   cpm_key_t              keyState_q;
   cpm_pm_t               pmState_q;
   logic [PWR_MODE_W-1:0] lowMode_q;
   logic [RCW-1:0]        resumeCnt_q;
   logic [6:0]            divCnt_q;
   logic                  extPrev_q;
   logic                  lockPrev_q;
   logic                  hit;
   logic                  wrEn;
   logic                  pwrCommit;
   logic                  clkCommit;
   logic                  wakeEv;
   logic                  wakeDone;
   logic                  irqAny;
   logic                  extRise;
   logic                  advance;
   logic                  extSync;
   logic                  lockSync;
   logic [3:0]            irqSync;
   logic [DW-1:0]         rdData;
   logic [RCW-1:0]        resumeTgt;
   logic [RCW-1:0]        fastTgt;
   logic [6:0]            divMask;
   logic [7:0]            mask8;
   logic [PWR_MODE_W-1:0] newMode;
   logic [PWR_DIV_W-1:0]  divSel;
   logic [CLK_MODE_W-1:0] clkMode;

   // pins; lock resets high so power-up does not look like a lock event
   cpm_sync #(
      .W   (6),
      .RST (6'h10)
   ) u_sync (
      .mclk (mclk),
      .nrst (nrst),
      .din  ({extClkPin, pllLockIn, extIrqIn}),
      .dout ({extSync, lockSync, irqSync})
   );

   assign newMode = stage_q[PWR_MODE_LSB +: PWR_MODE_W];
   assign divSel  = pwrCtl_q[PWR_DIV_LSB +: PWR_DIV_W];
   assign clkMode = clkCtl_q[CLK_MODE_LSB +: CLK_MODE_W];
   assign irqAny  = |irqSync;

   // apb decode; zero wait state, access phase follows setup
   always_comb begin
      hit = (paddr == OFF_PWR_KEY1) || (paddr == OFF_PWR_CTL) || (paddr == OFF_PWR_KEY2) ||
            (paddr == OFF_CLK_KEY1) || (paddr == OFF_CLK_CTL) || (paddr == OFF_CLK_KEY2);
      rdData = '0;
      if (paddr == OFF_PWR_CTL) begin
         rdData = {24'h000000, pwrCtl_q};
      end else if (paddr == OFF_CLK_CTL) begin
         rdData = {24'h000000, clkCtl_q};
      end
   end

   assign wrEn = psel & penable & pready & pwrite & hit;

   // answer flops; key registers are write only and read zero
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit;
         prdata  <= (psel & ~penable & ~pwrite) ? rdData : '0;
      end
   end

   // commit only on the closing key right after the staged value
   assign pwrCommit = wrEn && keyState_q == KEY_PWR2 && paddr == OFF_PWR_KEY2 &&
                      pwdata[15:0] == PWR_KEY2_VAL;
   assign clkCommit = wrEn && keyState_q == KEY_CLK2 && paddr == OFF_CLK_KEY2 &&
                      pwdata[15:0] == CLK_KEY2_VAL;

   // key sequencer; any stray write to a decoded register drops the sequence
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         keyState_q <= KEY_IDLE;
         stage_q    <= '0;
      end else if (wrEn) begin
         if (paddr == OFF_PWR_KEY1 && pwdata[15:0] == PWR_KEY1_VAL) begin
            keyState_q <= KEY_PWR1;
         end else if (paddr == OFF_CLK_KEY1 && pwdata[15:0] == CLK_KEY1_VAL) begin
            keyState_q <= KEY_CLK1;
         end else begin
            case (keyState_q)
               KEY_PWR1: begin
                  keyState_q <= (paddr == OFF_PWR_CTL) ? KEY_PWR2 : KEY_IDLE;
                  stage_q    <= pwdata[CW-1:0] & PWR_CTL_MASK;
               end
               KEY_CLK1: begin
                  keyState_q <= (paddr == OFF_CLK_CTL) ? KEY_CLK2 : KEY_IDLE;
                  stage_q    <= pwdata[CW-1:0] & CLK_CTL_MASK;
               end
               default: keyState_q <= KEY_IDLE;
            endcase
         end
      end
   end

   // clock source control word; reserved bits dropped on write
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         clkCtl_q <= CLK_CTL_RST;
      end else if (clkCommit) begin
         clkCtl_q <= stage_q;
      end
   end

   // power control word; hardware returns the mode to normal on wake,
   // a commit in that same cycle wins since it is the newer request
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pwrCtl_q <= PWR_CTL_RST;
      end else if (pwrCommit) begin
         pwrCtl_q <= stage_q;
      end else if (wakeDone) begin
         pwrCtl_q[PWR_MODE_LSB +: PWR_MODE_W] <= MODE_NORMAL;
      end
   end

   // wake sources per mode; stop keeps only the interrupt pins alive
   always_comb begin
      case (lowMode_q)
         MODE_STOP: wakeEv = irqAny;
         default:   wakeEv = irqAny | wakeTimerIrq;
      endcase
   end

   // pause and nap resume time scales with the divider, capped at the slowest figure; sleep and stop use fixed counts
   always_comb begin
      fastTgt = RCW'(FAST_CYC) << divSel;
      case (lowMode_q)
         MODE_SLEEP: resumeTgt = RCW'(SLEEP_RESUME_CYC);
         MODE_STOP:  resumeTgt = RCW'(STOP_RESUME_CYC);
         default:    resumeTgt = (fastTgt > RCW'(SLOW_CYC)) ? RCW'(SLOW_CYC) : fastTgt;
      endcase
   end

   assign wakeDone = (pmState_q == PM_RESUME) && (resumeCnt_q == '0);

   // power mode sequencer; reserved mode codes leave the device active
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pmState_q   <= PM_ACTIVE;
         lowMode_q   <= MODE_NORMAL;
         resumeCnt_q <= '0;
      end else begin
         case (pmState_q)
            PM_ACTIVE: begin
               if (pwrCommit && newMode >= MODE_PAUSE && newMode <= MODE_STOP) begin
                  pmState_q <= PM_LOW;
                  lowMode_q <= newMode;
               end
            end
            PM_LOW: begin
               if (wakeEv) begin
                  pmState_q   <= PM_RESUME;
                  resumeCnt_q <= resumeTgt - 1'b1;
               end
            end
            PM_RESUME: begin
               if (resumeCnt_q == '0) begin
                  pmState_q <= PM_ACTIVE;
                  lowMode_q <= MODE_NORMAL;
               end else begin
                  resumeCnt_q <= resumeCnt_q - 1'b1;
               end
            end
            default: pmState_q <= PM_ACTIVE;
         endcase
      end
   end

   // source switchover only at a timer wake from nap, so the core never
   // sees a glitch while it runs; reserved codes keep the old source
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         extClkSelect <= 1'b0;
      end else if (pmState_q == PM_LOW && lowMode_q == MODE_NAP && wakeTimerIrq) begin
         if (clkMode == CLK_MODE_EXT) begin
            extClkSelect <= 1'b1;
         end else if (clkMode == CLK_MODE_PLL) begin
            extClkSelect <= 1'b0;
         end
      end
   end

   // reference select follows the committed word
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pllRefInternal <= CLK_CTL_RST[CLK_REF_BIT];
      end else begin
         pllRefInternal <= clkCtl_q[CLK_REF_BIT];
      end
   end

   // domain gates; core also waits for lock when running from the pll
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         coreClkEn   <= 1'b0;
         periphClkEn <= 1'b1;
         pllEn       <= 1'b1;
         xtalTimerEn <= 1'b1;
      end else begin
         coreClkEn   <= pmState_q == PM_ACTIVE && (extClkSelect || lockSync);
         periphClkEn <= !(pmState_q == PM_LOW && lowMode_q >= MODE_NAP);
         pllEn       <= !(pmState_q == PM_LOW && lowMode_q >= MODE_SLEEP);
         xtalTimerEn <= !(pmState_q == PM_LOW && lowMode_q == MODE_STOP);
      end
   end

   // core tick divider; the pin is sampled on mclk, so only external
   // clocks well below half of mclk are followed edge for edge
   assign extRise = extSync & ~extPrev_q;
   assign advance = coreClkEn & (extClkSelect ? extRise : 1'b1);
   assign mask8   = (8'h01 << divSel) - 8'h01;
   assign divMask = mask8[6:0];

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         divCnt_q  <= '0;
         coreTick  <= 1'b0;
         extPrev_q <= 1'b0;
      end else begin
         extPrev_q <= extSync;
         coreTick  <= advance && ((divCnt_q & divMask) == divMask);
         if (advance) begin
            divCnt_q <= divCnt_q + 7'h01;
         end
      end
   end

   // lock return raises a one-cycle interrupt
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lockPrev_q <= 1'b1;
         pllIrq     <= 1'b0;
      end else begin
         lockPrev_q <= lockSync;
         pllIrq     <= lockSync & ~lockPrev_q;
      end
   end

   // checks
   localparam int FAST_BOUND = 80;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   property p_clk_guard;
      $changed(clkCtl_q) |-> $past(clkCommit);
   endproperty
   a_clk_guard: assert property (p_clk_guard) else $error("clock word changed without keys");

   property p_pwr_guard;
      $changed(pwrCtl_q) |-> $past(pwrCommit) || $past(wakeDone);
   endproperty
   a_pwr_guard: assert property (p_pwr_guard) else $error("power word changed without keys");

   property p_src_code;
      $changed(extClkSelect) |-> $past(clkMode) == (extClkSelect ? CLK_MODE_EXT : CLK_MODE_PLL);
   endproperty
   a_src_code: assert property (p_src_code) else $error("source does not match mode code");

   property p_src_wake;
      $changed(extClkSelect) |-> $past(pmState_q == PM_LOW && lowMode_q == MODE_NAP && wakeTimerIrq);
   endproperty
   a_src_wake: assert property (p_src_wake) else $error("source switched outside timer wake");

   property p_ref_sel;
      clkCommit |-> ##2 pllRefInternal == $past(stage_q[CLK_REF_BIT], 2);
   endproperty
   a_ref_sel: assert property (p_ref_sel) else $error("reference select not applied");

   property p_mode_legal;
      pwrCommit && pmState_q == PM_ACTIVE && newMode > MODE_STOP |=> pmState_q == PM_ACTIVE;
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("reserved mode entered low power");

   property p_div_gap;
      coreTick && divSel != '0 && !extClkSelect && $stable(divSel) |=> !coreTick;
   endproperty
   a_div_gap: assert property (p_div_gap) else $error("divided tick too close");

   property p_ext_tick;
      coreTick && extClkSelect |-> $past(extRise);
   endproperty
   a_ext_tick: assert property (p_ext_tick) else $error("tick without external edge");

   property p_gate_stop;
      pmState_q == PM_LOW && lowMode_q == MODE_STOP |=> !coreClkEn && !periphClkEn && !pllEn && !xtalTimerEn;
   endproperty
   a_gate_stop: assert property (p_gate_stop) else $error("domain left on in stop");

   property p_gate_nap;
      pmState_q == PM_LOW && lowMode_q == MODE_NAP |=> !coreClkEn && !periphClkEn && pllEn;
   endproperty
   a_gate_nap: assert property (p_gate_nap) else $error("wrong gating in nap");

   property p_fast_resume;
      $rose(pmState_q == PM_RESUME) && lowMode_q <= MODE_NAP |-> ##[1:FAST_BOUND] pmState_q == PM_ACTIVE;
   endproperty
   a_fast_resume: assert property (p_fast_resume) else $error("pause or nap resume too slow");

   property p_lock_halt;
      !lockSync && !extClkSelect |=> !coreClkEn;
   endproperty
   a_lock_halt: assert property (p_lock_halt) else $error("core ran without lock");

   property p_lock_irq;
      $rose(lockSync) |=> pllIrq;
   endproperty
   a_lock_irq: assert property (p_lock_irq) else $error("no interrupt on lock return");

   c_nap: cover property (pmState_q == PM_LOW && lowMode_q == MODE_NAP);
   c_clk: cover property (clkCommit);
   c_switch: cover property ($rose(extClkSelect));
   c_irq: cover property (pllIrq);
endmodule

// *** inc/cpm_pkg.sv ***
// cpm_pkg: register map, field layout, key values, modes and timing
// of the clock source and power mode controller.
// assumes a 25 MHz mclk and an APB master with 32-bit data.
package cpm_pkg;
   localparam int AW = 32;
   localparam int DW = 32;
   localparam int CW = 8;
   localparam int RCW = 16;

   // byte addresses of the register words
   localparam logic [AW-1:0] OFF_PWR_KEY1 = 32'hFFFF0404;
   localparam logic [AW-1:0] OFF_PWR_CTL  = 32'hFFFF0408;
   localparam logic [AW-1:0] OFF_PWR_KEY2 = 32'hFFFF040C;
   localparam logic [AW-1:0] OFF_CLK_KEY1 = 32'hFFFF0410;
   localparam logic [AW-1:0] OFF_CLK_CTL  = 32'hFFFF0414;
   localparam logic [AW-1:0] OFF_CLK_KEY2 = 32'hFFFF0418;

   // reset values and implemented-bit masks
   localparam logic [CW-1:0] PWR_CTL_RST  = 8'h03;
   localparam logic [CW-1:0] CLK_CTL_RST  = 8'h21;
   localparam logic [CW-1:0] PWR_CTL_MASK = 8'h77;
   localparam logic [CW-1:0] CLK_CTL_MASK = 8'h23;

   // key values
   localparam logic [15:0] CLK_KEY1_VAL = 16'h00AA;
   localparam logic [15:0] CLK_KEY2_VAL = 16'h0055;
   localparam logic [15:0] PWR_KEY1_VAL = 16'h0001;
   localparam logic [15:0] PWR_KEY2_VAL = 16'h00F4;

   // field positions
   localparam int CLK_MODE_LSB = 0;
   localparam int CLK_MODE_W   = 2;
   localparam int CLK_REF_BIT  = 5;
   localparam int PWR_MODE_LSB = 4;
   localparam int PWR_MODE_W   = 3;
   localparam int PWR_DIV_LSB  = 0;
   localparam int PWR_DIV_W    = 3;

   // clocking mode codes
   localparam logic [CLK_MODE_W-1:0] CLK_MODE_PLL = 2'h1;
   localparam logic [CLK_MODE_W-1:0] CLK_MODE_EXT = 2'h3;

   // operating mode codes
   localparam logic [PWR_MODE_W-1:0] MODE_NORMAL = 3'h0;
   localparam logic [PWR_MODE_W-1:0] MODE_PAUSE  = 3'h1;
   localparam logic [PWR_MODE_W-1:0] MODE_NAP    = 3'h2;
   localparam logic [PWR_MODE_W-1:0] MODE_SLEEP  = 3'h3;
   localparam logic [PWR_MODE_W-1:0] MODE_STOP   = 3'h4;

   // timing
   localparam int CLK_PERIOD_NS   = 40;
   localparam int EXT_CLK_MAX_KHZ = 41780;
   localparam int T_FAST_NS       = 24;
   localparam int T_SLOW_NS       = 3060;
   localparam int T_SLEEP_US      = 1580;
   localparam int T_STOP_US       = 1700;
   localparam int FAST_CYC  = (T_FAST_NS / CLK_PERIOD_NS < 1) ? 1 : T_FAST_NS / CLK_PERIOD_NS;
   localparam int SLOW_CYC  = (T_SLOW_NS / CLK_PERIOD_NS < 1) ? 1 : T_SLOW_NS / CLK_PERIOD_NS;
   localparam int SLEEP_CYC = T_SLEEP_US * 1000 / CLK_PERIOD_NS;
   localparam int STOP_CYC  = T_STOP_US * 1000 / CLK_PERIOD_NS;

   typedef enum logic [2:0] {KEY_IDLE, KEY_PWR1, KEY_PWR2, KEY_CLK1, KEY_CLK2} cpm_key_t;
   typedef enum logic [1:0] {PM_ACTIVE, PM_LOW, PM_RESUME} cpm_pm_t;
endpackage

// *** design/cpm_sync.sv ***
// cpm_sync: three-stage synchroniser with agreement filter.
// assumes asynchronous inputs; output changes once stages two and three agree.
`timescale 1ns/1ps
module cpm_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         mclk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1Q;
   logic [W-1:0] s2Q;
   logic [W-1:0] s3Q;

   // stage one is read by stage two only
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         s1Q  <= RST;
         s2Q  <= RST;
         s3Q  <= RST;
         dout <= RST;
      end else begin
         s1Q <= din;
         s2Q <= s1Q;
         s3Q <= s2Q;
         for (int i = 0; i < W; i++) begin
            if (s2Q[i] == s3Q[i]) begin
               dout[i] <= s3Q[i];
            end
         end
      end
   end
endmodule

// *** test/test_clock_power_mode_control.sv ***
// test_clock_power_mode_control: self-checking bench for cpm_ctrl.
// assumes cpm_pkg compiled first; sleep and stop resume shortened to 20 cycles.
`timescale 1ns/1ps
module test_clock_power_mode_control;
   import cpm_pkg::*;
   logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, er;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic        extClkPin, pllLockIn, wakeTimerIrq, coreClkEn, periphClkEn, pllEn;
   logic        xtalTimerEn, extClkSelect, pllRefInternal, coreTick, pllIrq;
   logic [3:0]  extIrqIn;
   int          n_mismatch, tests_run, pwrM, clkM, keyM, stgM, n, cd, m, e, ticks;
   localparam logic [31:0] ADR [8] = '{OFF_PWR_KEY1, OFF_PWR_CTL, OFF_PWR_KEY2, OFF_CLK_KEY1,
                                       OFF_CLK_CTL, OFF_CLK_KEY2, 32'hFFFF0400, 32'hFFFF041C};
   // broken key sequences: bare write, wrong second key, stray write after first key
   localparam logic [31:0] BA [7] = '{OFF_CLK_CTL, OFF_PWR_KEY1, OFF_PWR_CTL, OFF_PWR_KEY2,
                                      OFF_CLK_KEY1, OFF_PWR_KEY2, OFF_CLK_CTL};
   localparam logic [31:0] BD [7] = '{32'h03, 32'h01, 32'h20, 32'hF5, 32'hAA, 32'hF4, 32'h03};

   cpm_ctrl #(.SLEEP_RESUME_CYC(20), .STOP_RESUME_CYC(20)) cpm_ctrl_inst (
      .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .extClkPin(extClkPin),
      .pllLockIn(pllLockIn), .extIrqIn(extIrqIn), .wakeTimerIrq(wakeTimerIrq), .coreClkEn(coreClkEn),
      .periphClkEn(periphClkEn), .pllEn(pllEn), .xtalTimerEn(xtalTimerEn), .extClkSelect(extClkSelect),
      .pllRefInternal(pllRefInternal), .coreTick(coreTick), .pllIrq(pllIrq));

   initial mclk = 1'b0;
   always #20 mclk = ~mclk;
   // tick counter, sampled values only
   always @(posedge mclk) if (coreTick === 1'b1) ticks++;

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      tests_run++;
      if (got !== ex) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic final_report();
      if (n_mismatch == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // reference model of the key sequencing; a wrong write always disarms
   function automatic void mdl_wr(input logic [31:0] a, input logic [31:0] d);
      int s;
      s = 0;
      if (a == OFF_PWR_KEY1 && d[15:0] == PWR_KEY1_VAL) s = 1;
      else if (a == OFF_CLK_KEY1 && d[15:0] == CLK_KEY1_VAL) s = 3;
      else if ((a == OFF_PWR_CTL && keyM == 1) || (a == OFF_CLK_CTL && keyM == 3)) s = keyM + 1;
      else if (a == OFF_PWR_KEY2 && d[15:0] == PWR_KEY2_VAL && keyM == 2) pwrM = stgM & 32'h77;
      else if (a == OFF_CLK_KEY2 && d[15:0] == CLK_KEY2_VAL && keyM == 4) clkM = stgM & 32'h23;
      if (s == 2 || s == 4) stgM = d;
      keyM = s;
   endfunction

   // one APB transfer; request held until pready is sampled high
   task automatic apb(input bit wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // no local limit: only the watchdog ends a stuck access phase
      do begin
         @(posedge mclk);
      end while (pready !== 1'b1);
      chk("pready", 1, pready);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (wr) mdl_wr(a, d);
   endtask

   task automatic rdchk(input logic [31:0] a);
      apb(1'b0, a, $urandom);
      chk("read data", (a == OFF_PWR_CTL) ? pwrM : (a == OFF_CLK_CTL) ? clkM : 0, rd);
      chk("read error", !(a inside {ADR[0], ADR[1], ADR[2], ADR[3], ADR[4], ADR[5]}), er);
   endtask

   // keyed writes; upper key bits are random since only bits 15:0 count
   task automatic pw(input logic [31:0] v);
      apb(1'b1, OFF_PWR_KEY1, {16'($urandom), PWR_KEY1_VAL});
      apb(1'b1, OFF_PWR_CTL, v);
      apb(1'b1, OFF_PWR_KEY2, {16'($urandom), PWR_KEY2_VAL});
   endtask

   task automatic ck(input logic [31:0] v);
      apb(1'b1, OFF_CLK_KEY1, {16'($urandom), CLK_KEY1_VAL});
      apb(1'b1, OFF_CLK_CTL, v);
      apb(1'b1, OFF_CLK_KEY2, {16'($urandom), CLK_KEY2_VAL});
   endtask

   task automatic gates(input logic c, input logic p, input logic l, input logic x);
      chk("gates", {c, p, l, x}, {coreClkEn, periphClkEn, pllEn, xtalTimerEn});
   endtask

   task automatic waitcore(input logic v);
      n = 0;
      while (coreClkEn !== v && n < 200) begin
         @(posedge mclk);
         n++;
      end
   endtask

   task automatic waittick();
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (coreTick !== 1'b1 && n < 300);
   endtask

   // wake from low power by timer or by one external interrupt line
   task automatic wake(input bit useIrq);
      if (useIrq) extIrqIn <= 4'(1 << $urandom_range(0, 3));
      else wakeTimerIrq <= 1'b1;
      waitcore(1'b1);
      extIrqIn     <= 4'h0;
      wakeTimerIrq <= 1'b0;
      pwrM = pwrM & 7;
   endtask

   // hang guard, far beyond the thousand or so cycles the run needs
   initial begin
      repeat (30000) @(posedge mclk);
      n_mismatch++;
      final_report();
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {nrst, extClkPin, wakeTimerIrq, extIrqIn} = '0;
      pllLockIn = 1'b1;
      {keyM, stgM, ticks} = '0;
      pwrM = PWR_CTL_RST;
      clkM = CLK_CTL_RST;
      void'($urandom(32'h6c86bec5));
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      waitcore(1'b1);
      gates(1, 1, 1, 1);
      chk("source after reset", 2'b10, {pllRefInternal, extClkSelect});
      foreach (ADR[i]) rdchk(ADR[i]);
      foreach (BA[i]) apb(1'b1, BA[i], BD[i]);
      rdchk(OFF_PWR_CTL);
      rdchk(OFF_CLK_CTL);
      // a read between the keys must not disarm the sequence
      apb(1'b1, OFF_CLK_KEY1, 32'hAA);
      rdchk(OFF_PWR_CTL);
      apb(1'b1, OFF_CLK_CTL, 32'h01);
      rdchk(OFF_CLK_CTL);
      apb(1'b1, OFF_CLK_KEY2, 32'h55);
      repeat (3) @(posedge mclk);
      rdchk(OFF_CLK_CTL);
      chk("crystal reference", 0, pllRefInternal);
      // every mode code, then one reserved code
      for (m = 1; m <= 5; m++) begin
         cd = (m == 1) ? 7 : $urandom_range(0, 3);
         pw((m << 4) | cd);
         repeat (4) @(posedge mclk);
         gates(m == 5, m == 1 || m == 5, m <= 2 || m == 5, m != 4);
         rdchk(OFF_PWR_CTL);
         if (m < 5) begin
            e = (m >= 3) ? 20 : (((1 << cd) < 76) ? (1 << cd) : 76);
            wake(m == 4);
            chk("resume time", 1, 32'(n >= e && n <= e + 10));
            rdchk(OFF_PWR_CTL);
            gates(1, 1, 1, 1);
         end
         else pw(32'h00);
      end
      // divider period on the PLL source
      for (m = 0; m < 5; m++) begin
         cd = (m == 4) ? $urandom_range(4, 7) : m;
         pw(cd);
         repeat (2) waittick();
         waittick();
         chk("tick period", 1 << cd, n);
      end
      pllLockIn <= 1'b0;
      waitcore(1'b0);
      chk("halt delay", 1, 32'(n <= 8));
      repeat (10) @(posedge mclk);
      chk("halted core", 0, coreClkEn);
      pllLockIn <= 1'b1;
      n = 0;
      while (pllIrq !== 1'b1 && n < 12) begin
         @(posedge mclk);
         n++;
      end
      chk("lock interrupt", 1, pllIrq);
      @(posedge mclk);
      chk("lock interrupt pulse", 0, pllIrq);
      waitcore(1'b1);
      chk("core restarted", 1, coreClkEn);
      // source switch is held back until the nap wake
      ck(32'h03);
      repeat (3) @(posedge mclk);
      rdchk(OFF_CLK_CTL);
      chk("source before nap", 0, extClkSelect);
      pw(32'h27);
      repeat (4) @(posedge mclk);
      chk("source in nap", 0, extClkSelect);
      wake(1'b0);
      chk("source after wake", 1, extClkSelect);
      pw(32'h00);
      ticks = 0;
      repeat (40) @(posedge mclk);
      chk("ticks with idle pin", 0, ticks);
      repeat (40) begin
         repeat (4) @(posedge mclk);
         extClkPin <= ~extClkPin;
      end
      repeat (10) @(posedge mclk);
      chk("external ticks", 20, ticks);
      // reserved source code leaves the selection as it was
      ck(32'h22);
      pw(32'h20);
      repeat (4) @(posedge mclk);
      wake(1'b0);
      chk("reserved source", 2'b11, {pllRefInternal, extClkSelect});
      final_report();
   end
endmodule
